// >>> hw/fdma_cfg.svh
// Overview of operation
// (R1) main system role: only FIFO input 0 is enabled, fed by chain manager samples
// (R2) node role: only FIFO input 1 is enabled, fed by the motor data collector
// (R3) processor controls the engine through the AXI4 subordinate port
// (R4) engine writes memory itself as an AXI4 manager
// (R5) control bit 0 runs the transfer; control bits 2 to 7 are reserved
// (R6) writing control bit 1 while the engine is idle reloads the current pointer with destination start
// (R7) destination start at 0x04, 32-bit read/write, resets to zero
// (R8) destination limit at 0x08, 32-bit read/write, resets to zero
// (R9) write status in bits 2:0 at 0x0C, read only, upper bits zero
// (R10) read status in bits 2:0 at 0x10, also answered at 0x1C
// (R11) words go to incrementing addresses from start, never past the limit
`ifndef FDMA_CFG_SVH
`define FDMA_CFG_SVH
`define FDMA_OFS_CONTROL 8'h00
`define FDMA_OFS_DST_START 8'h04
`define FDMA_OFS_DST_LIMIT 8'h08
`define FDMA_OFS_WR_STATUS 8'h0C
`define FDMA_OFS_RD_STATUS 8'h10
`define FDMA_OFS_RD_STATUS_ALT 8'h1C
`define FDMA_BIT_RUN 0
`define FDMA_BIT_RELOAD 1
`define FDMA_RST_ADDR 32'h0000_0000
`define FDMA_RST_CONTROL 2'h0
`define FDMA_ADDR_STEP 32'h0000_0004
`define FDMA_RESP_OKAY 2'h0
`define FDMA_RESP_SLVERR 2'h2
`endif

// >>> hw/fdma_pkg.sv
`default_nettype none
package fdma_pkg;
   typedef enum logic [3:0] {
      FDMA_IDLE = 4'h1,
      FDMA_ADDR = 4'h2,
      FDMA_DATA = 4'h4,
      FDMA_RESP = 4'h8
   } fdma_state_t;
   typedef struct packed {
      logic [2:0] code;
   } fdma_status_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
   } fdma_beat_t;
endpackage
`default_nettype wire

// >>> hw/fdma_top.sv
`include "fdma_cfg.svh"
`default_nettype none
module fdma_top import fdma_pkg::*; #(
   parameter bit NODE_ROLE = 1'b0
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // fifo inputs: 0 is chain manager, 1 is data collector
   input wire logic [31:0] fifo0_data,
   input wire logic fifo0_valid,
   output logic fifo0_ready,
   input wire logic [31:0] fifo1_data,
   input wire logic fifo1_valid,
   output logic fifo1_ready,
   // axi4 subordinate (control)
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // axi4 manager (memory writes, single beats)
   output logic [31:0] m_awaddr,
   output logic [7:0] m_awlen,
   output logic [2:0] m_awsize,
   output logic [1:0] m_awburst,
   output logic m_awvalid,
   input wire logic m_awready,
   output logic [31:0] m_wdata,
   output logic [3:0] m_wstrb,
   output logic m_wlast,
   output logic m_wvalid,
   input wire logic m_wready,
   input wire logic [1:0] m_bresp,
   input wire logic m_bvalid,
   output logic m_bready
);
   // ---------------------------------------------
   // register slave
   // ---------------------------------------------
   logic [1:0] ctrl_q, ctrl_d;
   logic [31:0] start_q, start_d, limit_q, limit_d;
   logic s_awready_q, s_awready_d, s_wready_q, s_wready_d, s_bvalid_q, s_bvalid_d;
   logic [1:0] s_bresp_q, s_bresp_d, s_rresp_q, s_rresp_d;
   logic s_arready_q, s_arready_d, s_rvalid_q, s_rvalid_d;
   logic [31:0] s_rdata_q, s_rdata_d;
   logic reload_q, reload_d;
   fdma_status_t wr_stat_q, wr_stat_d, rd_stat_q, rd_stat_d;

   function automatic logic fdma_known(input logic [7:0] a, input logic rd);
      fdma_known = (a == `FDMA_OFS_CONTROL) || (a == `FDMA_OFS_DST_START) ||
                   (a == `FDMA_OFS_DST_LIMIT) ||
                   (rd && ((a == `FDMA_OFS_WR_STATUS) || (a == `FDMA_OFS_RD_STATUS) ||
                           (a == `FDMA_OFS_RD_STATUS_ALT)));
   endfunction

   function automatic logic [31:0] fdma_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] st);
      fdma_merge = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            fdma_merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction

   logic wr_go;
   logic [31:0] ctrl_m;
   assign wr_go = s_awvalid && s_wvalid && !s_bvalid_q && !s_awready_q;
   assign ctrl_m = fdma_merge({30'h0, ctrl_q}, s_wdata, s_wstrb);

   always_comb begin
      ctrl_d = ctrl_q;
      start_d = start_q;
      limit_d = limit_q;
      s_awready_d = 1'b0;
      s_wready_d = 1'b0;
      s_bvalid_d = s_bvalid_q && !s_bready;
      s_bresp_d = s_bresp_q;
      reload_d = 1'b0;
      s_arready_d = 1'b0;
      s_rvalid_d = s_rvalid_q && !s_rready;
      s_rdata_d = s_rvalid_d ? s_rdata_q : 32'h0000_0000;
      s_rresp_d = s_rresp_q;
      if (wr_go) begin // [R3]
         s_awready_d = 1'b1;
         s_wready_d = 1'b1;
         s_bvalid_d = 1'b1;
         s_bresp_d = fdma_known(s_awaddr, 1'b0) ? `FDMA_RESP_OKAY : `FDMA_RESP_SLVERR;
         case (s_awaddr)
            `FDMA_OFS_CONTROL: begin
               // reserved bits 2..7 are dropped; bit 1 is a strobe that reads back zero
               ctrl_d = {1'b0, ctrl_m[`FDMA_BIT_RUN]}; // [R5]
               reload_d = ctrl_m[`FDMA_BIT_RELOAD] && s_wstrb[0]; // [R6]
            end
            `FDMA_OFS_DST_START: start_d = fdma_merge(start_q, s_wdata, s_wstrb); // [R7]
            `FDMA_OFS_DST_LIMIT: limit_d = fdma_merge(limit_q, s_wdata, s_wstrb); // [R8]
            default: ;
         endcase
      end
      if (s_arvalid && !s_rvalid_q && !s_arready_q) begin // [R3]
         s_arready_d = 1'b1;
         s_rvalid_d = 1'b1;
         s_rresp_d = fdma_known(s_araddr, 1'b1) ? `FDMA_RESP_OKAY : `FDMA_RESP_SLVERR;
         case (s_araddr)
            `FDMA_OFS_CONTROL: s_rdata_d = {30'h0, ctrl_q};
            `FDMA_OFS_DST_START: s_rdata_d = start_q;
            `FDMA_OFS_DST_LIMIT: s_rdata_d = limit_q;
            `FDMA_OFS_WR_STATUS: s_rdata_d = {29'h0, wr_stat_q.code}; // [R9]
            `FDMA_OFS_RD_STATUS, `FDMA_OFS_RD_STATUS_ALT: s_rdata_d = {29'h0, rd_stat_q.code}; // [R10]
            default: s_rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= `FDMA_RST_CONTROL;
         start_q <= `FDMA_RST_ADDR;
         limit_q <= `FDMA_RST_ADDR;
         s_awready_q <= 1'b0;
         s_wready_q <= 1'b0;
         s_bvalid_q <= 1'b0;
         s_bresp_q <= `FDMA_RESP_OKAY;
         reload_q <= 1'b0;
         s_arready_q <= 1'b0;
         s_rvalid_q <= 1'b0;
         s_rdata_q <= 32'h0000_0000;
         s_rresp_q <= `FDMA_RESP_OKAY;
      end else if (clk_en) begin
         ctrl_q <= ctrl_d;
         start_q <= start_d;
         limit_q <= limit_d;
         s_awready_q <= s_awready_d;
         s_wready_q <= s_wready_d;
         s_bvalid_q <= s_bvalid_d;
         s_bresp_q <= s_bresp_d;
         reload_q <= reload_d;
         s_arready_q <= s_arready_d;
         s_rvalid_q <= s_rvalid_d;
         s_rdata_q <= s_rdata_d;
         s_rresp_q <= s_rresp_d;
      end
   end

   // ---------------------------------------------
   // transfer engine
   // ---------------------------------------------
   fdma_state_t st_q, st_d;
   fdma_beat_t beat_q, beat_d;
   logic [31:0] ptr_q, ptr_d;
   logic aw_q, aw_d, w_q, w_d, f0r_q, f0r_d, f1r_q, f1r_d;
   logic bready_q, bready_d;
   logic [31:0] src_data;
   logic src_valid, in_range;

   // the role selects one input; the other is held off permanently
   assign src_data = NODE_ROLE ? fifo1_data : fifo0_data; // [R1] [R2]
   assign src_valid = NODE_ROLE ? fifo1_valid : fifo0_valid; // [R1] [R2]
   assign in_range = (ptr_q <= limit_q);

   always_comb begin
      st_d = st_q;
      beat_d = beat_q;
      ptr_d = ptr_q;
      aw_d = aw_q;
      w_d = w_q;
      f0r_d = 1'b0;
      f1r_d = 1'b0;
      wr_stat_d = wr_stat_q;
      rd_stat_d = rd_stat_q;
      case (st_q)
         FDMA_IDLE: begin
            if (reload_q) begin
               ptr_d = start_q; // [R6]
               wr_stat_d.code = 3'h0;
               rd_stat_d.code = 3'h0;
            end else if (ctrl_q[`FDMA_BIT_RUN] && src_valid && !f0r_q && !f1r_q) begin // [R5]
               if (in_range) begin // [R11]
                  f0r_d = !NODE_ROLE; // [R1]
                  f1r_d = NODE_ROLE; // [R2]
                  beat_d.addr = ptr_q;
                  beat_d.data = src_data;
                  rd_stat_d.code = 3'h1;
                  st_d = FDMA_ADDR;
               end else begin
                  // region full: stop taking words rather than wrap
                  rd_stat_d.code = 3'h2;
                  wr_stat_d.code = 3'h2;
               end
            end
         end
         FDMA_ADDR: begin
            aw_d = 1'b1; // [R4]
            w_d = 1'b1;
            wr_stat_d.code = 3'h1;
            st_d = FDMA_DATA;
         end
         FDMA_DATA: begin
            if (m_awready) aw_d = 1'b0;
            if (m_wready) w_d = 1'b0;
            if ((!aw_q || m_awready) && (!w_q || m_wready)) st_d = FDMA_RESP;
         end
         FDMA_RESP: begin
            if (m_bvalid) begin
               ptr_d = ptr_q + `FDMA_ADDR_STEP; // [R11]
               wr_stat_d.code = (m_bresp == `FDMA_RESP_OKAY) ? 3'h4 : 3'h3;
               rd_stat_d.code = 3'h4;
               st_d = FDMA_IDLE;
            end
         end
         default: st_d = FDMA_IDLE;
      endcase
      // registered so that the response ready leaves a flip-flop, high exactly while waiting
      bready_d = (st_d == FDMA_RESP);
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= FDMA_IDLE;
         beat_q <= '0;
         ptr_q <= `FDMA_RST_ADDR;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         f0r_q <= 1'b0;
         f1r_q <= 1'b0;
         bready_q <= 1'b0;
         wr_stat_q <= '0;
         rd_stat_q <= '0;
      end else if (clk_en) begin
         st_q <= st_d;
         beat_q <= beat_d;
         ptr_q <= ptr_d;
         aw_q <= aw_d;
         w_q <= w_d;
         f0r_q <= f0r_d;
         f1r_q <= f1r_d;
         bready_q <= bready_d;
         wr_stat_q <= wr_stat_d;
         rd_stat_q <= rd_stat_d;
      end
   end

   assign fifo0_ready = f0r_q;
   assign fifo1_ready = f1r_q;
   assign s_awready = s_awready_q;
   assign s_wready = s_wready_q;
   assign s_bvalid = s_bvalid_q;
   assign s_bresp = s_bresp_q;
   assign s_arready = s_arready_q;
   assign s_rvalid = s_rvalid_q;
   assign s_rdata = s_rdata_q;
   assign s_rresp = s_rresp_q;
   assign m_awaddr = beat_q.addr;
   assign m_awlen = 8'h00;
   assign m_awsize = 3'h2;
   assign m_awburst = 2'h1;
   assign m_awvalid = aw_q;
   assign m_wdata = beat_q.data;
   assign m_wstrb = 4'hF;
   assign m_wlast = w_q;
   assign m_wvalid = w_q;
   assign m_bready = bready_q;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   chk_role_select: assert property (NODE_ROLE ? !fifo0_ready : !fifo1_ready) // [R1] [R2]
      else $error("inactive fifo input was popped");
   chk_run_gate: assert property (((fifo0_ready || fifo1_ready) && clk_en) |-> $past(ctrl_q[0])) // [R5]
      else $error("word taken while run bit clear");
   chk_reload_ptr: assert property ((reload_q && clk_en && st_q == FDMA_IDLE) |=> ptr_q == $past(start_q)) // [R6]
      else $error("reload did not load start address");
   chk_range_hold: assert property ((m_awvalid) |-> m_awaddr <= limit_q || $changed(limit_q)) // [R11]
      else $error("write beyond destination limit");
   chk_ptr_step: assert property ((st_q == FDMA_RESP && m_bvalid && clk_en) |=> ptr_q == $past(ptr_q) + 32'h4) // [R11]
      else $error("pointer did not step by one word");
   chk_axi_hold: assert property ((m_awvalid && !m_awready) |=> m_awvalid && $stable(m_awaddr)) // [R4]
      else $error("manager address dropped before accept");
   chk_bresp_slot: assert property ((s_awvalid && s_wvalid && !s_bvalid && !s_awready && clk_en) |=> s_bvalid) // [R3]
      else $error("write not answered in one cycle");
   chk_status_rsvd: assert property (($rose(s_rvalid) && ($past(s_araddr) inside {`FDMA_OFS_WR_STATUS, // [R9] [R10]
                                     `FDMA_OFS_RD_STATUS, `FDMA_OFS_RD_STATUS_ALT})) |-> s_rdata[31:3] == 29'h0)
      else $error("reserved status bits set");
   chk_start_write: assert property ((s_awvalid && s_wvalid && !s_bvalid && !s_awready && clk_en && // [R7]
                                     s_awaddr == 8'h04 && s_wstrb == 4'hF) |=> start_q == $past(s_wdata))
      else $error("start address not written");
   chk_limit_write: assert property ((s_awvalid && s_wvalid && !s_bvalid && !s_awready && clk_en && // [R8]
                                     s_awaddr == 8'h08 && s_wstrb == 4'hF) |=> limit_q == $past(s_wdata))
      else $error("limit address not written");
   cov_word_done: cover property (st_q == FDMA_RESP && m_bvalid);
   cov_region_full: cover property (ctrl_q[0] && src_valid && !in_range);
   cov_reload: cover property (reload_q);
   cov_bad_addr: cover property (s_bvalid && s_bresp == 2'h2);
endmodule
`default_nettype wire

// >>> sim/fdma_mem_model.sv
`default_nettype none
module fdma_mem_model (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [31:0] m_awaddr,
   input wire logic m_awvalid,
   output logic m_awready,
   input wire logic [31:0] m_wdata,
   input wire logic m_wvalid,
   output logic m_wready,
   output logic [1:0] m_bresp,
   output logic m_bvalid,
   input wire logic m_bready,
   input wire logic [3:0] slow,
   input wire logic err,
   output logic [31:0] seen_addr,
   output logic [31:0] seen_data,
   output logic [7:0] seen_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_q;
   // -----------------------------------------------------------
   // memory slave: takes address and data together after slow idle cycles
   // -----------------------------------------------------------
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         m_awready <= 1'b0;
         m_wready <= 1'b0;
         m_bvalid <= 1'b0;
         m_bresp <= 2'h0;
         wait_q <= 4'h0;
         seen_cnt <= 8'h0;
      end else begin
         m_awready <= 1'b0;
         m_wready <= 1'b0;
         if (m_awvalid && m_wvalid && !m_awready && !m_bvalid) begin
            wait_q <= wait_q + 4'h1;
            if (wait_q >= slow) begin
               m_awready <= 1'b1;
               m_wready <= 1'b1;
               wait_q <= 4'h0;
               seen_addr <= m_awaddr;
               seen_data <= m_wdata;
               seen_cnt <= seen_cnt + 8'h1;
            end
         end
         if (m_awready) begin
            m_bvalid <= 1'b1;
            m_bresp <= err ? 2'h2 : 2'h0;
         end else if (m_bvalid && m_bready) begin
            // response no longer valid: show garbage, not the old code
            m_bvalid <= 1'b0;
            m_bresp <= ~m_bresp;
         end
      end
   end
endmodule
`default_nettype wire

// >>> sim/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, resetn, clk_en, fifo0_valid, fifo0_ready, fifo1_valid, fifo1_ready, f1_seen;
   logic [31:0] fifo0_data, fifo1_data, s_wdata, s_rdata, m_awaddr, m_wdata, seen_addr, seen_data;
   logic [7:0] s_awaddr, s_araddr, m_awlen, seen_cnt;
   logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
   logic [1:0] s_bresp, s_rresp, m_awburst, m_bresp;
   logic [2:0] m_awsize;
   logic [3:0] s_wstrb, m_wstrb, slow;
   logic m_awvalid, m_awready, m_wlast, m_wvalid, m_wready, m_bvalid, m_bready, err;
   logic n_f0, n_f1, n0_seen, n1_seen;
   int bad_count, n_tests;
   fdma_top #(.NODE_ROLE(1'b0)) uut (.*);
   // node-role copy shares the register bus; its memory side always accepts, both fifo inputs offer words
   fdma_top #(.NODE_ROLE(1'b1)) uut_node (.*, .fifo0_valid(1'b1), .fifo0_ready(n_f0), .fifo1_ready(n_f1),
      .s_awready(), .s_wready(), .s_bresp(), .s_bvalid(), .s_arready(), .s_rdata(), .s_rresp(), .s_rvalid(),
      .m_awaddr(), .m_awlen(), .m_awsize(), .m_awburst(), .m_awvalid(), .m_awready(1'b1), .m_wdata(),
      .m_wstrb(), .m_wlast(), .m_wvalid(), .m_wready(1'b1), .m_bresp(2'h0), .m_bvalid(1'b1), .m_bready());
   fdma_mem_model mem (.*);
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (!resetn) begin
         f1_seen <= 1'b0;
         n0_seen <= 1'b0;
         n1_seen <= 1'b0;
      end else begin
         if (fifo1_ready !== 1'b0) f1_seen <= 1'b1;
         if (n_f0 !== 1'b0) n0_seen <= 1'b1;
         if (n_f1 === 1'b1) n1_seen <= 1'b1;
      end
   end
   // -----------------------------------------------------------
   // shared tasks: reg_wr, reg_rd, push and no_pop start and end 10 ns after an edge; await returns on the edge
   // -----------------------------------------------------------
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic await(ref logic sig, input string what);
      int i;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (sig !== 1'b1 && i < 60);
      if (sig !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %s expected 1 seen timeout", what);
         complete_run();
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      s_awaddr = a;
      s_wdata = d;
      s_awvalid = 1'b1;
      s_wvalid = 1'b1;
      s_bready = 1'b1;
      await(s_bvalid, "write response");
      check("write accept", 32'h3, {30'h0, s_awready, s_wready});
      check("write resp", {30'h0, er}, {30'h0, s_bresp});
      #10;
      s_awvalid = 1'b0;
      s_wvalid = 1'b0;
      s_bready = 1'b0;
      @(posedge core_clk);
      #10;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
      s_araddr = a;
      s_arvalid = 1'b1;
      s_rready = 1'b1;
      await(s_rvalid, "read response");
      check("read accept", 32'h1, {31'h0, s_arready});
      check(what, exp, s_rdata);
      check("read resp", {30'h0, er}, {30'h0, s_rresp});
      #10;
      s_arvalid = 1'b0;
      s_rready = 1'b0;
      @(posedge core_clk);
      #10;
   endtask
   task automatic push(input logic [31:0] w, input logic [31:0] a);
      logic [31:0] beat;
      fifo0_data = w;
      fifo0_valid = 1'b1;
      await(fifo0_ready, "fifo pop");
      #10;
      fifo0_valid = 1'b0;
      fifo0_data = ~w;
      // one edge after the pop both channels stand: single-beat incrementing word write
      @(posedge core_clk);
      beat = {12'h000, m_awvalid, m_wvalid, m_wlast, m_awlen, m_awsize, m_awburst, m_wstrb};
      check("manager beat", {12'h000, 3'h7, 8'h00, 3'h2, 2'h1, 4'hF}, beat);
      await(m_bvalid, "memory response");
      check("memory address", a, seen_addr);
      check("memory data", w, seen_data);
      #10;
   endtask
   task automatic no_pop(input string what);
      logic seen;
      seen = 1'b0;
      fifo0_valid = 1'b1;
      repeat (12) begin
         @(posedge core_clk);
         seen = seen | fifo0_ready;
      end
      check(what, 32'h0, {31'h0, seen});
      #10;
      fifo0_valid = 1'b0;
   endtask
   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   task automatic t_reset();
      reg_rd(8'h00, 32'h0, 2'h0, "control");
      reg_rd(8'h04, 32'h0, 2'h0, "start");
      reg_rd(8'h08, 32'h0, 2'h0, "limit");
      reg_rd(8'h0C, 32'h0, 2'h0, "write status");
      reg_rd(8'h10, 32'h0, 2'h0, "read status");
      reg_rd(8'h1C, 32'h0, 2'h0, "read status alt");
      reg_rd(8'h20, 32'h0, 2'h2, "unmapped");
   endtask
   task automatic t_regs();
      reg_wr(8'h04, 32'h0000_1000, 2'h0);
      reg_wr(8'h08, 32'h0000_1008, 2'h0);
      reg_rd(8'h04, 32'h0000_1000, 2'h0, "start");
      reg_rd(8'h08, 32'h0000_1008, 2'h0, "limit");
      reg_wr(8'h0C, 32'hFFFF_FFFF, 2'h2);
      reg_wr(8'h00, 32'h0000_00FE, 2'h0);
      reg_rd(8'h00, 32'h0, 2'h0, "control");
      no_pop("run off");
   endtask
   task automatic t_stream();
      reg_wr(8'h00, 32'h1, 2'h0);
      push(32'hA5A5_0001, 32'h0000_1000);
      slow = 4'h3;
      push(32'h5A5A_0002, 32'h0000_1004);
      slow = 4'h0;
      reg_rd(8'h0C, 32'h4, 2'h0, "write status");
      push(32'hC3C3_0003, 32'h0000_1008);
      no_pop("past limit");
      reg_rd(8'h0C, 32'h2, 2'h0, "write status");
      reg_rd(8'h1C, 32'h2, 2'h0, "read status");
   endtask
   task automatic t_freeze();
      logic got;
      got = 1'b0;
      clk_en = 1'b0;
      s_awaddr = 8'h04;
      s_wdata = 32'hDEAD_BEEF;
      s_awvalid = 1'b1;
      s_wvalid = 1'b1;
      s_bready = 1'b1;
      repeat (6) begin
         @(posedge core_clk);
         got = got | s_bvalid | s_awready;
      end
      #10;
      s_awvalid = 1'b0;
      s_wvalid = 1'b0;
      s_bready = 1'b0;
      clk_en = 1'b1;
      check("frozen write answer", 32'h0, {31'h0, got});
      @(posedge core_clk);
      #10;
      reg_rd(8'h04, 32'h0000_1000, 2'h0, "start after freeze");
   endtask
   task automatic t_reload_err();
      reg_wr(8'h00, 32'h2, 2'h0);
      reg_wr(8'h00, 32'h1, 2'h0);
      err = 1'b1;
      push(32'h0F0F_0004, 32'h0000_1000);
      err = 1'b0;
      reg_rd(8'h0C, 32'h3, 2'h0, "write status");
   endtask
   initial begin
      {resetn, fifo0_valid, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, err} = '0;
      {fifo0_data, s_wdata, s_awaddr, s_araddr, slow} = '0;
      s_wstrb = 4'hF;
      clk_en = 1'b1;
      fifo1_valid = 1'b1;
      fifo1_data = 32'h1111_1111;
      bad_count = 0;
      n_tests = 0;
      repeat (12) @(posedge core_clk);
      #10;
      resetn = 1'b1;
      @(posedge core_clk);
      #10;
      t_reset();
      t_regs();
      t_stream();
      t_freeze();
      t_reload_err();
      check("second input pops", 32'h0, {31'h0, f1_seen});
      check("node first input pops", 32'h0, {31'h0, n0_seen});
      check("node second input pops", 32'h1, {31'h0, n1_seen});
      complete_run();
   end
endmodule
`default_nettype wire
